/* File: common/stdc_defines.svh */
// Register offsets, field positions and reset values of the tick timer
// Notes on behaviour
// R1: A 24-bit counter counts down from the restart value toward zero.
// R2: After reaching zero the restart value loads on the next tick, then counting resumes.
// R3: While the processor is halted for debug the counter holds its value.
// R4: Zero-reached flag at bit 16 reads 1 if zero was reached since last read; read clears.
// R5: Bit 2 selects the tick: 0 gives clock divided by eight, 1 the processor clock.
// R6: Bit 1 set lets reaching zero raise the exception request; clear keeps it low.
// R7: Enable at bit 0 first loads the restart value, then counts; enable low stops counting.
// R8: Each zero sets the flag, raises the request if enabled, reloads and keeps counting.
// R9: Control register resets to 0x00000004: processor clock, everything else off.
// R10: Software keeps reserved control bits 15:3 and 31:17 at zero.
// R11: Only privileged software reaches the control register; this timer has no privilege input and accepts every access.
// R12: Restart value is 24 bits read-write at offset 0x04, reset to zero.
// R13: Any write to current count at 0x08 clears the count and the flag.
// R14: A restart value of zero gives no flag and no exception request.
// R15: Divided source decrements once per eight clocks through an enable pulse.
`ifndef STDC_DEFINES_SVH
`define STDC_DEFINES_SVH
`define STDC_OFF_CTRL 4'h0
`define STDC_OFF_RELOAD 4'h4
`define STDC_OFF_COUNT 4'h8
`define STDC_BIT_ENABLE 0
`define STDC_BIT_IRQEN 1
`define STDC_BIT_SOURCE 2
`define STDC_BIT_FLAG 16
`define STDC_SOURCE_RESET 1'b1
`define STDC_CNT_W 24
`define STDC_DIV 8
`define STDC_DIV_W 3
`define STDC_RESP_OKAY 2'b00
`define STDC_RESP_SLVERR 2'b10
`endif

/* File: common/stdc_pkg.sv */
// Types of the tick timer
package stdc_pkg;
  typedef logic [23:0] stdc_count_t;
  typedef enum logic [2:0] {
    STDC_IDLE = 3'b001,
    STDC_LOAD = 3'b010,
    STDC_RUN = 3'b100
  } stdc_state_t;
endpackage

/* File: logic/stdc_prescale.sv */
// Tick enable generator: every clock or one in eight
`timescale 1ns/100ps
`include "stdc_defines.svh"
module stdc_prescale #(
  parameter int DIV = `STDC_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic full_rate,
  output logic tick
);
  logic [`STDC_DIV_W-1:0] div_count;

  // Divide-by-eight phase counter
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_count <= '0;
    end else if (div_count == `STDC_DIV_W'(DIV - 1)) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + `STDC_DIV_W'(1);
    end
  end

  // Enable pulse, never a derived clock [R5] [R15]
  always_comb begin
    tick = run && (full_rate || (div_count == `STDC_DIV_W'(DIV - 1)));
  end

  a_div_spacing: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
    (tick && !full_rate && run) ##1 (run && !full_rate)[*7] |-> !tick)
    else $error("divided tick came early");
endmodule // stdc_prescale

/* File: logic/stdc_timer.sv */
// Tick down counter with AXI4-Lite register slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "stdc_defines.svh"
module stdc_timer #(
  parameter int CNT_W = `STDC_CNT_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic debug_halt,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic tick_request
);
  import stdc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic halt_meta, halt_sync;
  logic aw_held, w_held;
  logic [3:0] aw_addr;
  logic do_write, do_read;
  logic enable, tick_irq_enable, tick_source_select, zero_reached_flag;
  stdc_count_t restart_value, current_count;
  stdc_state_t state;
  logic tick, hit_zero, wr_count, rd_ctrl;

  function automatic logic known_addr(input logic [3:0] a);
    return a == `STDC_OFF_CTRL || a == `STDC_OFF_RELOAD || a == `STDC_OFF_COUNT;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Debug halt synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_meta <= 1'b0;
      halt_sync <= 1'b0;
    end else begin
      halt_meta <= debug_halt;
      halt_sync <= halt_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write channels, either order
  assign do_write = aw_held && w_held && !s_bvalid;
  assign wr_count = do_write && aw_addr == `STDC_OFF_COUNT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      s_awready <= 1'b0;
    end else if (s_awvalid && s_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_awaddr;
      s_awready <= 1'b0;
    end else begin
      s_awready <= !aw_held && !s_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      s_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
      s_wready <= 1'b0;
    end else if (s_wvalid && s_wready) begin
      w_held <= 1'b1;
      s_wready <= 1'b0;
    end else begin
      s_wready <= !w_held && !s_bvalid;
    end
  end

  logic [31:0] wdata;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata <= '0;
    end else if (s_wvalid && s_wready) begin
      wdata <= s_wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= `STDC_RESP_OKAY;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      s_bresp <= known_addr(aw_addr) ? `STDC_RESP_OKAY : `STDC_RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control and restart registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= 1'b0;
      tick_irq_enable <= 1'b0;
      tick_source_select <= `STDC_SOURCE_RESET; // [R9]
    end else if (do_write && aw_addr == `STDC_OFF_CTRL) begin
      enable <= wdata[`STDC_BIT_ENABLE];
      tick_irq_enable <= wdata[`STDC_BIT_IRQEN];
      tick_source_select <= wdata[`STDC_BIT_SOURCE];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_value <= '0; // [R12]
    end else if (do_write && aw_addr == `STDC_OFF_RELOAD) begin
      restart_value <= wdata[CNT_W-1:0]; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Counter
  stdc_prescale #(.DIV(`STDC_DIV)) u_prescale (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state == STDC_RUN && !halt_sync),
    .full_rate(tick_source_select),
    .tick(tick)
  );

  // Count from one to zero only [R14]
  assign hit_zero = tick && current_count == stdc_count_t'(1) && !wr_count;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= STDC_IDLE;
    end else begin
      case (state)
        STDC_IDLE: if (enable) state <= STDC_LOAD; // [R7]
        STDC_LOAD: state <= enable ? STDC_RUN : STDC_IDLE;
        STDC_RUN: if (!enable) state <= STDC_IDLE; // [R7]
        default: state <= STDC_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_count <= '0;
    end else if (wr_count) begin
      current_count <= '0; // [R13]
    end else if (state == STDC_LOAD) begin
      current_count <= restart_value; // [R7]
    end else if (tick) begin
      // Held while halted through the tick gate [R3]
      if (current_count == '0) begin
        current_count <= restart_value; // [R2]
      end else begin
        current_count <= current_count - stdc_count_t'(1); // [R1]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Flag, request and read channel
  assign do_read = s_arvalid && s_arready;
  assign rd_ctrl = do_read && s_araddr == `STDC_OFF_CTRL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      zero_reached_flag <= 1'b0;
    end else if (hit_zero) begin
      zero_reached_flag <= 1'b1; // [R8]
    end else if (rd_ctrl || wr_count) begin
      zero_reached_flag <= 1'b0; // [R4] [R13]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_request <= 1'b0;
    end else begin
      tick_request <= hit_zero && tick_irq_enable; // [R6] [R8]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= `STDC_RESP_OKAY;
    end else if (do_read) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= known_addr(s_araddr) ? `STDC_RESP_OKAY : `STDC_RESP_SLVERR;
      s_rdata <= '0;
      case (s_araddr)
        `STDC_OFF_CTRL: begin
          s_rdata[`STDC_BIT_ENABLE] <= enable;
          s_rdata[`STDC_BIT_IRQEN] <= tick_irq_enable;
          s_rdata[`STDC_BIT_SOURCE] <= tick_source_select;
          s_rdata[`STDC_BIT_FLAG] <= zero_reached_flag; // [R4]
        end
        `STDC_OFF_RELOAD: s_rdata[CNT_W-1:0] <= restart_value;
        `STDC_OFF_COUNT: s_rdata[CNT_W-1:0] <= current_count;
        default: s_rdata <= '0;
      endcase
    end else if (s_rvalid) begin
      if (s_rready) s_rvalid <= 1'b0;
    end else begin
      s_arready <= !s_arready;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_zero_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
    hit_zero |=> zero_reached_flag) else $error("flag not set at zero");
  a_zero_reloads: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    (tick && current_count == '0 && !wr_count && state == STDC_RUN)
    |=> current_count == $past(restart_value)) else $error("no reload after zero");
  a_decrement: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    (tick && current_count != '0 && !wr_count && state == STDC_RUN)
    |=> current_count == $past(current_count) - stdc_count_t'(1))
    else $error("bad decrement");
  a_halt_holds: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    (halt_sync && state == STDC_RUN && !wr_count && $past(halt_sync))
    |=> current_count == $past(current_count)) else $error("count moved while halted");
  a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    tick_request |-> $past(tick_irq_enable) && $past(hit_zero))
    else $error("request without cause");
  a_irq_raised: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    (hit_zero && tick_irq_enable) |=> tick_request) else $error("request missing");
  a_write_clears: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
    wr_count |=> current_count == '0 && !zero_reached_flag) else $error("clear failed");
  a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    (rd_ctrl && !hit_zero) |=> !zero_reached_flag) else $error("flag not cleared");
  a_enable_loads: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    (state == STDC_LOAD && !wr_count) |=> current_count == $past(restart_value))
    else $error("no load on enable");
  a_stopped_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    (state == STDC_IDLE && !wr_count) |=> current_count == $past(current_count))
    else $error("count moved while stopped");
  a_zero_reload_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    (current_count == '0 && restart_value == '0) |=> current_count == '0 && !tick_request)
    else $error("zero restart value left zero");

  c_wrap: cover property (@(posedge aclk) hit_zero ##[1:20] hit_zero);
  c_irq: cover property (@(posedge aclk) tick_request);
  c_flag_read: cover property (@(posedge aclk) zero_reached_flag ##1 rd_ctrl);
  c_halt: cover property (@(posedge aclk) state == STDC_RUN && halt_sync);
endmodule // stdc_timer

/* File: verification/tb_top.sv */
// Self-checking bench for the tick down counter and its register slave
`timescale 1ns/100ps
`include "stdc_defines.svh"
module tb_top;
  import stdc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic debug_halt = 1'b0;
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'hf;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, tick_request;
  logic [1:0] s_bresp, s_rresp, r;
  logic [31:0] s_rdata, a, b;
  int mismatches = 0, n_checks = 0, cyc = 0, n;
  always #12.5 aclk = ~aclk;
  stdc_timer dut (.aclk(aclk), .aresetn(aresetn), .debug_halt(debug_halt),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .tick_request(tick_request));
  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write one word; both channels offered together
  task automatic wr(input logic [3:0] ad, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_awaddr <= ad;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    s_araddr <= ad;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask
  // Edges up to and including the next request pulse
  task automatic wait_tick(output int k);
    k = 1;
    @(posedge aclk);
    while (tick_request !== 1'b1 && k < 500) begin
      @(posedge aclk);
      k++;
    end
  endtask
  task automatic count_ticks(input int c, output int k);
    k = 0;
    repeat (c) begin
      @(posedge aclk);
      if (tick_request === 1'b1) k++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`STDC_OFF_CTRL, a, r); chk(a, 32'h00000004);
    rd(`STDC_OFF_RELOAD, a, r); chk(a, 32'h0);
    rd(4'hc, a, r); chk({30'h0, r}, 32'h2);
    chk(a, 32'h0);
    wr(4'hc, 32'h1, r); chk({30'h0, r}, 32'h2);
    wr(`STDC_OFF_RELOAD, 32'h5, r); chk({30'h0, r}, 32'h0);
    rd(`STDC_OFF_RELOAD, a, r); chk(a, 32'h5);
    // Only privileged accesses, reserved control bits kept at zero
    wr(`STDC_OFF_CTRL, 32'h7, r);
    wait_tick(n);
    wait_tick(n); chk(n, 32'h6);
    wr(`STDC_OFF_CTRL, 32'h3, r);
    wait_tick(n);
    wait_tick(n); chk(n, 32'h30);
    wr(`STDC_OFF_CTRL, 32'h5, r);
    count_ticks(40, n); chk(n, 32'h0);
    wr(`STDC_OFF_CTRL, 32'h4, r);
    rd(`STDC_OFF_CTRL, a, r); chk(a, 32'h00010004);
    rd(`STDC_OFF_CTRL, a, r); chk(a, 32'h00000004);
    rd(`STDC_OFF_COUNT, a, r);
    repeat (10) @(posedge aclk);
    rd(`STDC_OFF_COUNT, b, r); chk(b, a);
    wr(`STDC_OFF_CTRL, 32'h5, r);
    repeat (20) @(posedge aclk);
    wr(`STDC_OFF_CTRL, 32'h4, r);
    wr(`STDC_OFF_COUNT, 32'h123, r);
    rd(`STDC_OFF_COUNT, a, r); chk(a, 32'h0);
    rd(`STDC_OFF_CTRL, a, r); chk(a, 32'h00000004);
    wr(`STDC_OFF_RELOAD, 32'd1000, r);
    wr(`STDC_OFF_CTRL, 32'h5, r);
    debug_halt <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`STDC_OFF_COUNT, a, r);
    repeat (20) @(posedge aclk);
    rd(`STDC_OFF_COUNT, b, r); chk(b, a);
    debug_halt <= 1'b0;
    repeat (6) @(posedge aclk);
    rd(`STDC_OFF_COUNT, b, r); chk({31'h0, b < a}, 32'h1);
    wr(`STDC_OFF_CTRL, 32'h4, r);
    wr(`STDC_OFF_RELOAD, 32'h0, r);
    rd(`STDC_OFF_CTRL, a, r);
    wr(`STDC_OFF_CTRL, 32'h7, r);
    count_ticks(30, n); chk(n, 32'h0);
    rd(`STDC_OFF_CTRL, a, r); chk(a, 32'h00000007);
    wr(`STDC_OFF_CTRL, 32'h4, r);
    wr(`STDC_OFF_RELOAD, 32'h00ffffff, r);
    rd(`STDC_OFF_RELOAD, a, r); chk(a, 32'h00ffffff);
    wr(`STDC_OFF_CTRL, 32'h5, r);
    rd(`STDC_OFF_COUNT, a, r); chk({24'h0, a[31:24]}, 32'h0);
    chk({31'h0, a >= 32'h00fff000}, 32'h1);
    wrap_up();
  end
endmodule // tb_top
